//--- hdl/pwm_ctrl_pkg.sv
package pwm_ctrl_pkg;

  localparam logic [7:0] ADDR_CONTROL_TWO = 8'h00;
  localparam logic [7:0] ADDR_DEAD_TIME = 8'h04;
  localparam logic [7:0] ADDR_DISABLE_MAP = 8'h08;
  localparam logic [7:0] ADDR_FAULT_CONTROL = 8'h0C;
  localparam logic [7:0] ADDR_FAULT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_FAULT_ACK = 8'h14;
  localparam logic [7:0] ADDR_MANUAL_OUT = 8'h18;

  // Control register two fields
  localparam int DIVIDER_LSB = 0;
  localparam int CORRECTION_LSB = 2;
  localparam int RELOAD_RATE_LSB = 6;

  // Fault control fields
  localparam int FAULT_A_MODE_BIT = 0;
  localparam int FAULT_A_IRQ_BIT = 1;
  localparam int FAULT_B_MODE_BIT = 2;
  localparam int FAULT_B_IRQ_BIT = 3;

  // Fault status and acknowledge fields
  localparam int FAULT_A_EVENT_BIT = 0;
  localparam int FAULT_A_LEVEL_BIT = 1;
  localparam int FAULT_B_EVENT_BIT = 2;
  localparam int FAULT_B_LEVEL_BIT = 3;

  // Manual output fields
  localparam int MANUAL_OVERRIDE_BIT = 7;

  localparam logic [7:0] RESET_CONTROL_TWO = 8'h00;
  localparam logic [7:0] RESET_DEAD_TIME = 8'h00;
  localparam logic [7:0] RESET_DISABLE_MAP = 8'h00;
  localparam logic [7:0] RESET_FAULT_CONTROL = 8'h00;
  localparam logic [7:0] RESET_MANUAL_OUT = 8'h00;

  typedef enum logic [1:0] {
    EN_OFF = 2'h0,
    EN_WAIT = 2'h1,
    EN_RUN = 2'h3
  } enable_state_e;

endpackage

//--- hdl/pwm_ctrl_regs.sv
module pwm_ctrl_regs #(
  parameter int CHANNELS = 6
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic module_enable,
  input wire logic load_permit,
  input wire logic cycle_start,
  input wire logic complementary_mode,
  input wire logic software_correction,
  input wire logic [CHANNELS-1:0] generator_levels,
  input wire logic fault_a_pin,
  input wire logic fault_b_pin,
  output logic reload_strobe,
  output logic load_permit_clear,
  output logic [1:0] counter_clock_divider,
  output logic [2:0] correction_active,
  output logic [7:0] dead_time,
  output logic [7:0] disable_map,
  output logic fault_a_recovery_mode,
  output logic fault_b_recovery_mode,
  output logic fault_a_event,
  output logic fault_b_event,
  output logic fault_irq,
  output logic [CHANNELS-1:0] output_levels,
  output logic [CHANNELS-1:0] pin_oe_n
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] rate_buf;
    logic [2:0] correction_buf;
    logic [1:0] divider_buf;
    logic [2:0] cycles_left;
    logic [1:0] divider_active;
    logic [2:0] correction_active;
    logic reload_strobe;
    logic load_permit_clear;
    logic [7:0] dead_time;
    logic dead_time_done;
    logic [7:0] disable_map;
    logic disable_map_done;
    logic [3:0] fault_control;
    logic fault_irq;
    logic manual_override;
    logic [CHANNELS-1:0] manual_pin_levels;
    pwm_ctrl_pkg::enable_state_e enable_state;
    logic [CHANNELS-1:0] output_levels;
    logic [CHANNELS-1:0] pin_oe_n;
  } state_s;

  state_s cur;
  state_s next_cur;

  logic access;
  logic wr;
  logic [CHANNELS-1:0] manual_drive;
  logic [CHANNELS-1:0] source_levels;
  logic pins_driven;
  logic fault_a_clear;
  logic fault_b_clear;
  logic fault_a_next;
  logic fault_b_next;
  logic fault_a_flag;
  logic fault_b_flag;

  always_comb
  begin
    next_cur = cur;
    access = psel && penable && cur.pready;
    wr = access && pwrite;
    manual_drive = '0;
    source_levels = '0;
    pins_driven = 1'b0;
    next_cur.reload_strobe = 1'b0;
    next_cur.load_permit_clear = 1'b0;

    // Two-cycle APB access: ready rises in the second access cycle
    next_cur.pready = psel && penable && !cur.pready;
    next_cur.pslverr = 1'b0;
    if (psel && penable && !cur.pready)
    begin
      next_cur.prdata = '0;
      if (paddr == pwm_ctrl_pkg::ADDR_CONTROL_TWO)
      begin
        next_cur.prdata[7:0] = {cur.rate_buf, 1'b0, cur.correction_buf,
                                cur.divider_buf};
      end
      else if (paddr == pwm_ctrl_pkg::ADDR_DEAD_TIME)
      begin
        next_cur.prdata[7:0] = cur.dead_time;
      end
      else if (paddr == pwm_ctrl_pkg::ADDR_DISABLE_MAP)
      begin
        next_cur.prdata[7:0] = cur.disable_map;
      end
      else if (paddr == pwm_ctrl_pkg::ADDR_FAULT_CONTROL)
      begin
        next_cur.prdata[3:0] = cur.fault_control;
      end
      else if (paddr == pwm_ctrl_pkg::ADDR_FAULT_STATUS)
      begin
        next_cur.prdata[pwm_ctrl_pkg::FAULT_A_EVENT_BIT] = fault_a_flag;
        next_cur.prdata[pwm_ctrl_pkg::FAULT_A_LEVEL_BIT] = fault_a_pin;
        next_cur.prdata[pwm_ctrl_pkg::FAULT_B_EVENT_BIT] = fault_b_flag;
        next_cur.prdata[pwm_ctrl_pkg::FAULT_B_LEVEL_BIT] = fault_b_pin;
      end
      else if (paddr == pwm_ctrl_pkg::ADDR_FAULT_ACK)
      begin
        next_cur.prdata = '0;
      end
      else if (paddr == pwm_ctrl_pkg::ADDR_MANUAL_OUT)
      begin
        next_cur.prdata[pwm_ctrl_pkg::MANUAL_OVERRIDE_BIT] = cur.manual_override;
        next_cur.prdata[CHANNELS-1:0] = cur.manual_pin_levels;
      end
      else
      begin
        next_cur.pslverr = 1'b1;
      end
    end

    if (wr && paddr == pwm_ctrl_pkg::ADDR_CONTROL_TWO)
    begin
      next_cur.rate_buf = pwdata[pwm_ctrl_pkg::RELOAD_RATE_LSB +: 2];
      next_cur.correction_buf = pwdata[pwm_ctrl_pkg::CORRECTION_LSB +: 3];
      next_cur.divider_buf = pwdata[pwm_ctrl_pkg::DIVIDER_LSB +: 2];
    end
    if (wr && paddr == pwm_ctrl_pkg::ADDR_DEAD_TIME && !cur.dead_time_done)
    begin
      next_cur.dead_time = pwdata[7:0];
      next_cur.dead_time_done = 1'b1;
    end
    if (wr && paddr == pwm_ctrl_pkg::ADDR_DISABLE_MAP && !cur.disable_map_done)
    begin
      next_cur.disable_map = pwdata[7:0];
      next_cur.disable_map_done = 1'b1;
    end
    if (wr && paddr == pwm_ctrl_pkg::ADDR_FAULT_CONTROL)
    begin
      next_cur.fault_control = pwdata[3:0];
    end
    if (wr && paddr == pwm_ctrl_pkg::ADDR_MANUAL_OUT)
    begin
      next_cur.manual_override = pwdata[pwm_ctrl_pkg::MANUAL_OVERRIDE_BIT];
      next_cur.manual_pin_levels = pwdata[CHANNELS-1:0];
    end

    // Reload bookkeeping at each generator cycle start
    if (cycle_start)
    begin
      if (software_correction)
      begin
        next_cur.correction_active = cur.correction_buf;
      end
      if (cur.cycles_left == 3'h0)
      begin
        next_cur.reload_strobe = 1'b1;
        // Rate is read only here, so a new one waits for this reload
        next_cur.cycles_left = 3'((4'h1 << cur.rate_buf) - 4'h1);
        if (load_permit)
        begin
          next_cur.divider_active = cur.divider_buf;
          next_cur.load_permit_clear = 1'b1;
        end
      end
      else
      begin
        next_cur.cycles_left = cur.cycles_left - 3'h1;
      end
    end

    // Event flags reach the protection logic ungated; only the irq is masked
    next_cur.fault_irq =
      (fault_a_next && cur.fault_control[pwm_ctrl_pkg::FAULT_A_IRQ_BIT]) ||
      (fault_b_next && cur.fault_control[pwm_ctrl_pkg::FAULT_B_IRQ_BIT]);

    // Enable sequencing; a nonzero divider holds the enable until the next cycle start
    case (cur.enable_state)
      pwm_ctrl_pkg::EN_OFF:
      begin
        if (module_enable)
        begin
          if (cur.divider_active != 2'h0)
          begin
            next_cur.enable_state = pwm_ctrl_pkg::EN_WAIT;
          end
          else
          begin
            next_cur.enable_state = pwm_ctrl_pkg::EN_RUN;
          end
        end
      end
      pwm_ctrl_pkg::EN_WAIT:
      begin
        if (!module_enable)
        begin
          next_cur.enable_state = pwm_ctrl_pkg::EN_OFF;
        end
        else if (cycle_start)
        begin
          next_cur.enable_state = pwm_ctrl_pkg::EN_RUN;
        end
      end
      pwm_ctrl_pkg::EN_RUN:
      begin
        if (!module_enable)
        begin
          next_cur.enable_state = pwm_ctrl_pkg::EN_OFF;
        end
      end
      default:
      begin
        next_cur.enable_state = pwm_ctrl_pkg::EN_OFF;
      end
    endcase

    // Manual levels; in complementary mode an odd pin is forced low while its even partner is high
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (complementary_mode && i % 2 == 1)
      begin
        manual_drive[i] = cur.manual_pin_levels[i] &&
                          !cur.manual_pin_levels[i-1];
      end
      else
      begin
        manual_drive[i] = cur.manual_pin_levels[i];
      end
    end
    // Generator keeps running; override switches the output source and enables the pins
    source_levels = cur.manual_override ? manual_drive : generator_levels;
    pins_driven = cur.manual_override ||
                  (cur.enable_state == pwm_ctrl_pkg::EN_RUN);
    next_cur.output_levels = source_levels;
    next_cur.pin_oe_n = pins_driven ? '0 : '1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cur <= '0;
      cur.rate_buf <= pwm_ctrl_pkg::RESET_CONTROL_TWO[pwm_ctrl_pkg::RELOAD_RATE_LSB +: 2];
      cur.correction_buf <= pwm_ctrl_pkg::RESET_CONTROL_TWO[pwm_ctrl_pkg::CORRECTION_LSB +: 3];
      cur.divider_buf <= pwm_ctrl_pkg::RESET_CONTROL_TWO[pwm_ctrl_pkg::DIVIDER_LSB +: 2];
      cur.dead_time <= pwm_ctrl_pkg::RESET_DEAD_TIME;
      cur.disable_map <= pwm_ctrl_pkg::RESET_DISABLE_MAP;
      cur.fault_control <= pwm_ctrl_pkg::RESET_FAULT_CONTROL[3:0];
      cur.manual_override <= pwm_ctrl_pkg::RESET_MANUAL_OUT[pwm_ctrl_pkg::MANUAL_OVERRIDE_BIT];
      cur.manual_pin_levels <= pwm_ctrl_pkg::RESET_MANUAL_OUT[CHANNELS-1:0];
      cur.enable_state <= pwm_ctrl_pkg::EN_OFF;
      cur.pin_oe_n <= '1;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // Acknowledge strobes; a written 0 leaves the flag alone
  assign fault_a_clear = psel && penable && pwrite && cur.pready &&
    paddr == pwm_ctrl_pkg::ADDR_FAULT_ACK && pwdata[pwm_ctrl_pkg::FAULT_A_EVENT_BIT];
  assign fault_b_clear = psel && penable && pwrite && cur.pready &&
    paddr == pwm_ctrl_pkg::ADDR_FAULT_ACK && pwdata[pwm_ctrl_pkg::FAULT_B_EVENT_BIT];

  fault_event_flag fault_a_unit (
    .clk(clk),
    .reset(reset),
    .pin(fault_a_pin),
    .clear(fault_a_clear),
    .next_flag(fault_a_next),
    .flag(fault_a_flag)
  );

  fault_event_flag fault_b_unit (
    .clk(clk),
    .reset(reset),
    .pin(fault_b_pin),
    .clear(fault_b_clear),
    .next_flag(fault_b_next),
    .flag(fault_b_flag)
  );

  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign reload_strobe = cur.reload_strobe;
  assign load_permit_clear = cur.load_permit_clear;
  assign counter_clock_divider = cur.divider_active;
  assign correction_active = cur.correction_active;
  assign dead_time = cur.dead_time;
  assign disable_map = cur.disable_map;
  assign fault_a_recovery_mode = cur.fault_control[pwm_ctrl_pkg::FAULT_A_MODE_BIT];
  assign fault_b_recovery_mode = cur.fault_control[pwm_ctrl_pkg::FAULT_B_MODE_BIT];
  assign fault_a_event = fault_a_flag;
  assign fault_b_event = fault_b_flag;
  assign fault_irq = cur.fault_irq;
  assign output_levels = cur.output_levels;
  assign pin_oe_n = cur.pin_oe_n;

endmodule // pwm_ctrl_regs

module fault_event_flag (
  input wire logic clk,
  input wire logic reset,
  input wire logic pin,
  input wire logic clear,
  output logic next_flag,
  output logic flag
);

  typedef struct packed {
    logic pin_prev;
    logic flag;
  } flag_state_s;

  flag_state_s cur;
  flag_state_s next_cur;

  always_comb
  begin
    next_cur = cur;
    // Previous sample resets low, the idle pin level, so no false edge
    next_cur.pin_prev = pin;
    if (clear)
    begin
      next_cur.flag = 1'b0;
    end
    // A rise in the acknowledge cycle wins, so no fault is lost
    if (pin && !cur.pin_prev)
    begin
      next_cur.flag = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cur <= '0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  assign next_flag = next_cur.flag;
  assign flag = cur.flag;

endmodule // fault_event_flag

//--- tb/power_stage_model.sv
module power_stage_model (
  input wire logic clk,
  input wire logic [1:0] trip,
  input wire logic [5:0] output_levels,
  input wire logic [5:0] pin_oe_n,
  output logic fault_a_pin = 1'h0,
  output logic fault_b_pin = 1'h0,
  output logic [5:0] pads
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sensors settle a clock after the trip, like a filtered comparator
  always @(posedge clk)
  begin
    fault_a_pin <= trip[0];
    fault_b_pin <= trip[1];
  end
  // Released pins sink to the gate driver pull-down
  assign pads = output_levels & ~pin_oe_n;
endmodule // power_stage_model

//--- tb/pwm_ctrl_props.sv
module pwm_ctrl_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cycle_start,
  input wire logic load_permit,
  input wire logic fault_a_pin,
  input wire logic fault_b_pin,
  input wire logic reload_strobe,
  input wire logic load_permit_clear,
  input wire logic fault_a_event,
  input wire logic fault_b_event,
  input wire logic fault_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_access_ready: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered in its second cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  a_unmapped_err: assert property (pready && paddr > 8'h18 |-> pslverr)
    else $error("unmapped access without error");
  a_ack_zero: assert property (pready && !pwrite && paddr == 8'h14 |-> prdata == 32'h0)
    else $error("acknowledge register read nonzero");
  a_rise_flags_a: assert property ($rose(fault_a_pin) |-> ##[1:2] fault_a_event)
    else $error("fault a flag late");
  a_rise_flags_b: assert property ($rose(fault_b_pin) |-> ##[1:2] fault_b_event)
    else $error("fault b flag late");
  a_irq_cause: assert property (fault_irq |-> fault_a_event || fault_b_event)
    else $error("fault irq without event");
  a_strobe_start: assert property (reload_strobe |-> $past(cycle_start))
    else $error("reload strobe without cycle start");
  a_clear_reload: assert property (
    load_permit_clear |-> reload_strobe && $past(load_permit))
    else $error("permit cleared outside a permitted reload");
  c_reload: cover property (load_permit_clear);
  c_irq: cover property (fault_irq);
  c_err: cover property (pready && pslverr);
endmodule // pwm_ctrl_props

bind pwm_ctrl_regs pwm_ctrl_props props_i (.clk, .reset, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .pslverr, .cycle_start, .load_permit, .fault_a_pin, .fault_b_pin,
  .reload_strobe, .load_permit_clear, .fault_a_event, .fault_b_event, .fault_irq);

//--- tb/testbench.sv
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, module_enable = 0;
  logic load_permit = 0, cycle_start = 0, complementary_mode = 0, software_correction = 0;
  logic [7:0] paddr = '0, dead_time, disable_map;
  logic [31:0] pwdata = '0, prdata;
  logic [5:0] generator_levels = '0, output_levels, pin_oe_n, pads, lv, e6;
  logic [1:0] trip = '0, counter_clock_divider;
  logic [2:0] correction_active;
  logic pready, pslverr, reload_strobe, load_permit_clear, fault_a_pin, fault_b_pin, fault_irq;
  logic fault_a_event, fault_b_event, fault_a_recovery_mode, fault_b_recovery_mode;
  logic [32:0] notes[$], nt;
  int error_cnt = 0, tests_run = 0, seed, n;
  always #5 clk = ~clk;
  pwm_ctrl_regs #(.CHANNELS(6)) DUT (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .module_enable, .load_permit, .cycle_start, .complementary_mode,
    .software_correction, .generator_levels, .fault_a_pin, .fault_b_pin, .reload_strobe,
    .load_permit_clear, .counter_clock_divider, .correction_active, .dead_time, .disable_map,
    .fault_a_recovery_mode, .fault_b_recovery_mode, .fault_a_event, .fault_b_event,
    .fault_irq, .output_levels, .pin_oe_n);
  power_stage_model stage (.clk, .trip, .output_levels, .pin_oe_n, .fault_a_pin,
    .fault_b_pin, .pads);
  always @(posedge clk)
    if (psel && penable && pready === 1'h1 && !pwrite)
    begin
      nt = notes.pop_front();
      `CHK("read", nt, {pslverr, prdata})
    end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    notes.push_back(e);
    apb(1'h0, a, '0);
  endtask
  task automatic pulse();
    cycle_start <= 1'h1;
    @(posedge clk);
    cycle_start <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    seed = 43786;
    repeat (20) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
      rd(8'(i * 4), {i == 7, 32'h0});
    apb(1'h1, pwm_ctrl_pkg::ADDR_CONTROL_TWO, 32'h02);
    rd(pwm_ctrl_pkg::ADDR_CONTROL_TWO, 33'h002);
    pulse();
    `CHK("strobe", 1'h1, reload_strobe)
    `CHK("div", 2'h0, counter_clock_divider)
    load_permit <= 1'h1;
    pulse();
    `CHK("clear", 1'h1, load_permit_clear)
    `CHK("div", 2'h2, counter_clock_divider)
    load_permit <= 1'h0;
    software_correction <= 1'h1;
    apb(1'h1, pwm_ctrl_pkg::ADDR_CONTROL_TWO, 32'h16);
    pulse();
    `CHK("corr", 3'h5, correction_active)
    software_correction <= 1'h0;
    apb(1'h1, pwm_ctrl_pkg::ADDR_CONTROL_TWO, 32'h0A);
    pulse();
    `CHK("corr", 3'h5, correction_active)
    // Warm-up starts let the old load cycle run out first
    for (int r = 0; r < 4; r++)
    begin
      apb(1'h1, pwm_ctrl_pkg::ADDR_CONTROL_TWO, {24'h0, 2'(r), 6'h02});
      repeat (16) pulse();
      n = 0;
      for (int k = 0; k < 16; k++)
      begin
        pulse();
        n += reload_strobe;
      end
      `CHK("reloads", 16 >> r, n)
    end
    // Rate change inside a long load cycle waits for that cycle to end
    do pulse(); while (reload_strobe !== 1'h1);
    apb(1'h1, pwm_ctrl_pkg::ADDR_CONTROL_TWO, 32'h02);
    n = 0;
    repeat (8)
    begin
      pulse();
      n += reload_strobe;
    end
    `CHK("hold", 32'h1, n)
    `CHK("end", 1'h1, reload_strobe)
    pulse();
    `CHK("next", 1'h1, reload_strobe)
    $display("test reload done");
    for (int i = 1; i < 3; i++)
    begin
      apb(1'h1, 8'(4 * i), 32'h5A);
      apb(1'h1, 8'(4 * i), 32'hA5);
      rd(8'(4 * i), 33'h05A);
    end
    `CHK("dead", 8'h5A, dead_time)
    `CHK("map", 8'h5A, disable_map)
    for (int p = 0; p < 2; p++)
    begin
      apb(1'h1, pwm_ctrl_pkg::ADDR_FAULT_CONTROL, 32'(3 << (2 * p)));
      `CHK("mode", 2'(1 << p), {fault_b_recovery_mode, fault_a_recovery_mode})
      trip[p] <= 1'h1;
      repeat (4) @(posedge clk);
      `CHK("irq", 1'h1, fault_irq)
      `CHK("event", 2'(1 << p), {fault_b_event, fault_a_event})
      rd(pwm_ctrl_pkg::ADDR_FAULT_STATUS, 33'(3 << (2 * p)));
      apb(1'h1, pwm_ctrl_pkg::ADDR_FAULT_ACK, 32'h0);
      rd(pwm_ctrl_pkg::ADDR_FAULT_STATUS, 33'(3 << (2 * p)));
      apb(1'h1, pwm_ctrl_pkg::ADDR_FAULT_ACK, 32'(1 << (2 * p)));
      `CHK("irq", 1'h0, fault_irq)
      `CHK("event", 2'h0, {fault_b_event, fault_a_event})
      rd(pwm_ctrl_pkg::ADDR_FAULT_STATUS, 33'(2 << (2 * p)));
      rd(pwm_ctrl_pkg::ADDR_FAULT_ACK, 33'h0);
      trip[p] <= 1'h0;
    end
    $display("test fault done");
    lv = 6'($random(seed));
    for (int c = 0; c < 2; c++)
    begin
      complementary_mode <= 1'(c);
      apb(1'h1, pwm_ctrl_pkg::ADDR_MANUAL_OUT, {24'h0, 2'h2, lv});
      @(posedge clk);
      e6 = lv & ~(6'(c * 42) & {lv[4:0], 1'h0});
      `CHK("levels", e6, output_levels)
      `CHK("pads", e6, pads)
    end
    generator_levels <= 6'($random(seed));
    apb(1'h1, pwm_ctrl_pkg::ADDR_MANUAL_OUT, 32'h0);
    @(posedge clk);
    `CHK("gen", generator_levels, output_levels)
    `CHK("oe", 6'h3F, pin_oe_n)
    module_enable <= 1'h1;
    repeat (6) @(posedge clk);
    `CHK("oe", 6'h3F, pin_oe_n)
    pulse();
    @(posedge clk);
    `CHK("oe", 6'h0, pin_oe_n)
    $display("test pins done");
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    `CHK("oe", 6'h3F, pin_oe_n)
    rd(pwm_ctrl_pkg::ADDR_DEAD_TIME, 33'h000);
    `CHK("oe", 6'h0, pin_oe_n)
    apb(1'h1, pwm_ctrl_pkg::ADDR_DEAD_TIME, 32'h33);
    rd(pwm_ctrl_pkg::ADDR_DEAD_TIME, 33'h033);
    $display("test rearm done");
    wrap_up();
  end
endmodule // testbench
